// [rtl/bsx_pkg.sv]
// package of constants and types for the byte subtract/xor/swap alu slice
// Function
// - literal minus accumulator to accumulator, updating carry, digit carry, zero
// - file minus accumulator to chosen destination, updating carry, digit carry, zero
// - accumulator xor literal to accumulator, zero flag only
// - accumulator xor file to chosen destination, zero flag only
// - nibble exchange of file register, no flag changes
// - destination bit zero selects accumulator, one writes file back; address 0..127
package bsx_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic        FLAG_RST = 1'b0;
    localparam logic [6:0]  WADDR_RST = 7'h00;
    localparam logic [7:0]  WDATA_RST = 8'h00;
    localparam int unsigned LAT_CYC = 1;  // op taken -> result valid

    // operation codes (gray along list)
    typedef enum logic [2:0] {
        BSX_OP_NONE    = 3'h0,
        BSX_OP_LSUB    = 3'h1,
        BSX_OP_FSUB    = 3'h3,
        BSX_OP_LXOR    = 3'h2,
        BSX_OP_FXOR    = 3'h6,
        BSX_OP_SWAP    = 3'h7
    } bsx_op_t;

    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // a minus b with carry (no borrow out of bit 7) and digit carry (bit 3)
    function automatic logic [9:0] bsx_sub(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        return {full[8], low[4], full[7:0]};
    endfunction

endpackage

// [rtl/bsx_alu.sv]
// byte-wide alu slice: subtract, xor and nibble exchange with flag updates
module bsx_alu
    import bsx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              op_valid,
    input  wire bsx_op_t           op_code,
    input  wire logic [7:0]        literal_in,
    input  wire logic [6:0]        file_addr,
    input  wire logic [7:0]        file_rdata,
    input  wire logic              dest_sel,
    output logic [7:0]             acc_out,
    output logic                   carry_flag,
    output logic                   digit_carry_flag,
    output logic                   zero_flag,
    output logic                   file_we,
    output logic [6:0]             file_waddr,
    output logic [7:0]             file_wdata
);

    ////////////////////////////////////////////////////////////////////////
    // state: accumulator and status flags
    logic [7:0] acc_q, acc_d;
    logic       c_q, c_d, dc_q, dc_d, z_q, z_d;
    // file write-back port; address and data stand until the next write
    logic       we_q, we_d;
    logic [6:0] wa_q, wa_d;
    logic [7:0] wd_q, wd_d;

    // next-value logic; one op is taken per edge and its result shows one
    // edge later, so back-to-back ops chain through the registered accumulator
    always_comb begin
        logic [9:0] sr;
        logic [7:0] res;
        logic       to_file;
        sr      = 10'h000;
        res     = 8'h00;
        to_file = 1'b0;
        // defaults hold every register and keep the strobe low
        acc_d = acc_q;
        c_d   = c_q;
        dc_d  = dc_q;
        z_d   = z_q;
        we_d  = 1'b0;      // write strobe is a single-cycle pulse
        wa_d  = wa_q;
        wd_d  = wd_q;
        // undefined codes fall to the default branch and change nothing
        if (op_valid) begin
            case (op_code)
                BSX_OP_LSUB: begin
                    sr  = bsx_sub(literal_in, acc_q);
                    res = sr[7:0];
                    c_d  = sr[9];
                    dc_d = sr[8];
                    z_d  = (res == 8'h00);
                end
                BSX_OP_FSUB: begin
                    sr  = bsx_sub(file_rdata, acc_q);
                    res = sr[7:0];
                    c_d  = sr[9];
                    dc_d = sr[8];
                    z_d  = (res == 8'h00);
                    to_file = dest_sel;
                end
                BSX_OP_LXOR: begin
                    res = acc_q ^ literal_in;
                    z_d = (res == 8'h00);
                end
                BSX_OP_FXOR: begin
                    res = acc_q ^ file_rdata;
                    z_d = (res == 8'h00);
                    to_file = dest_sel;
                end
                BSX_OP_SWAP: begin
                    res = {file_rdata[3:0], file_rdata[7:4]};
                    to_file = dest_sel;
                end
                default: begin
                    // refused codes write the accumulator back unchanged; BSX_OP_NONE skips the routing below
                    res = acc_q;
                end
            endcase
            // destination routing
            // literal ops never set to_file, so they always land in the accumulator
            if (op_code != BSX_OP_NONE) begin
                if (to_file == DEST_FILE) begin
                    we_d = 1'b1;
                    wa_d = file_addr;
                    wd_d = res;
                end else begin
                    acc_d = res;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers only; a synchronous reset keeps the flops clear of any
    // reset-release timing hazard
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_q <= ACC_RST;
            c_q   <= FLAG_RST;
            dc_q  <= FLAG_RST;
            z_q   <= FLAG_RST;
            we_q  <= 1'b0;
            wa_q  <= WADDR_RST;
            wd_q  <= WDATA_RST;
        end else begin
            acc_q <= acc_d;
            c_q   <= c_d;
            dc_q  <= dc_d;
            z_q   <= z_d;
            we_q  <= we_d;
            wa_q  <= wa_d;
            wd_q  <= wd_d;
        end
    end

    // outputs come straight from the flops
    assign acc_out          = acc_q;
    assign carry_flag       = c_q;
    assign digit_carry_flag = dc_q;
    assign zero_flag        = z_q;
    assign file_we          = we_q;
    assign file_waddr       = wa_q;
    assign file_wdata       = wd_q;

    ////////////////////////////////////////////////////////////////////////
    // checks: results are registered, so every assertion looks one edge on;
    // reset disables them, so an op cut short by reset is not judged
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // literal subtract lands in the accumulator
    a_lsub_result: assert property (op_valid && op_code == BSX_OP_LSUB |=>
        acc_q == 8'($past(literal_in) - $past(acc_q))) else $error("lsub result wrong");

    // file subtract to the accumulator leaves the file port quiet
    a_fsub_route: assert property (op_valid && op_code == BSX_OP_FSUB && !dest_sel |=>
        acc_q == 8'($past(file_rdata) - $past(acc_q)) && !we_q) else $error("fsub acc wrong");
    // file subtract to the file holds the accumulator
    a_fsub_file: assert property (op_valid && op_code == BSX_OP_FSUB && dest_sel |=>
        we_q && wd_q == 8'($past(file_rdata) - $past(acc_q)) && $stable(acc_q))
        else $error("fsub file write wrong");

    // literal xor keeps carry and digit carry, zero follows the result
    a_lxor_flags: assert property (op_valid && op_code == BSX_OP_LXOR |=>
        acc_q == ($past(literal_in) ^ $past(acc_q)) && $stable(c_q) && $stable(dc_q))
        else $error("lxor wrong");
    a_lxor_zero: assert property (op_valid && op_code == BSX_OP_LXOR |=>
        z_q == ($past(literal_in) == $past(acc_q))) else $error("lxor zero wrong");

    // file xor back to the file holds the accumulator
    a_fxor_file: assert property (op_valid && op_code == BSX_OP_FXOR && dest_sel |=>
        we_q && wd_q == ($past(file_rdata) ^ $past(acc_q)) && $stable(acc_q))
        else $error("fxor file wrong");
    // file xor sets zero only, on either destination
    a_fxor_zero: assert property (op_valid && op_code == BSX_OP_FXOR |=>
        z_q == ($past(file_rdata) == $past(acc_q)) && $stable(c_q) && $stable(dc_q))
        else $error("fxor flags wrong");

    // nibble exchange touches no flag on either destination
    a_swap_noflag: assert property (op_valid && op_code == BSX_OP_SWAP |=>
        $stable(c_q) && $stable(dc_q) && $stable(z_q)) else $error("swap touched flags");
    // swapped byte to the file port
    a_swap_data: assert property (op_valid && op_code == BSX_OP_SWAP && dest_sel |=>
        wd_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap data");
    // swapped byte to the accumulator, file port quiet
    a_swap_acc: assert property (op_valid && op_code == BSX_OP_SWAP && !dest_sel |=>
        acc_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !we_q)
        else $error("swap acc wrong");

    // the three file ops with the destination bit set write back, at the address they carried
    a_dest_addr: assert property (op_valid && dest_sel &&
        op_code inside {BSX_OP_FSUB, BSX_OP_FXOR, BSX_OP_SWAP} |=>
        we_q && wa_q == $past(file_addr)) else $error("file writeback missing");
    // literal ops ignore the destination bit
    a_lit_dest: assert property (op_valid &&
        op_code inside {BSX_OP_LSUB, BSX_OP_LXOR} |=>
        !we_q) else $error("literal op wrote file");
    // idle cycles and refused codes change nothing and raise no strobe
    a_idle_hold: assert property (!op_valid || !(op_code inside {BSX_OP_LSUB,
        BSX_OP_FSUB, BSX_OP_LXOR, BSX_OP_FXOR, BSX_OP_SWAP}) |=>
        $stable(acc_q) && $stable(c_q) && $stable(dc_q) && $stable(z_q) && !we_q)
        else $error("refused op changed state");
    // the strobe is a pulse: without a new op it drops after one cycle
    a_we_pulse: assert property (we_q && !op_valid |=> !we_q)
        else $error("write strobe stuck");
    // address and data stand until the next write-back
    a_wd_hold: assert property (!(op_valid && dest_sel &&
        op_code inside {BSX_OP_FSUB, BSX_OP_FXOR, BSX_OP_SWAP}) |=>
        $stable(wa_q) && $stable(wd_q)) else $error("write-back word moved");

    // carry: no borrow out of bit 7; zero: the byte result is zero
    a_sub_carry: assert property (op_valid && op_code == BSX_OP_LSUB |=>
        c_q == ($past(literal_in) >= $past(acc_q)) && z_q == (acc_q == 8'h00))
        else $error("carry or zero wrong");
    a_fsub_carry: assert property (op_valid && op_code == BSX_OP_FSUB |=>
        c_q == ($past(file_rdata) >= $past(acc_q)) &&
        z_q == ($past(file_rdata) == $past(acc_q)))
        else $error("fsub carry or zero wrong");
    // digit carry: no borrow out of bit 3
    a_sub_dc: assert property (op_valid && op_code == BSX_OP_FSUB |=>
        dc_q == ($past(file_rdata[3:0]) >= $past(acc_q[3:0]))) else $error("digit carry wrong");
    a_lsub_dc: assert property (op_valid && op_code == BSX_OP_LSUB |=>
        dc_q == ($past(literal_in[3:0]) >= $past(acc_q[3:0])))
        else $error("lsub digit carry wrong");

    // main scenarios: zero result, borrow, both destinations
    c_lsub: cover property (op_valid && op_code == BSX_OP_LSUB ##1 z_q);
    c_lsub_borrow: cover property (op_valid && op_code == BSX_OP_LSUB ##1 !c_q);
    c_fsub_file: cover property (op_valid && op_code == BSX_OP_FSUB && dest_sel);
    c_fxor_acc: cover property (op_valid && op_code == BSX_OP_FXOR && !dest_sel);
    c_swap_file: cover property (op_valid && op_code == BSX_OP_SWAP && dest_sel);

endmodule

// [verification/bsx_file_model.sv]
// behavioural file register array standing behind the alu slice
module bsx_file_model
    import bsx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [6:0] file_addr,
    input  wire logic       file_we,
    input  wire logic [6:0] file_waddr,
    input  wire logic [7:0] file_wdata,
    output logic      [7:0] file_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [128];
    ////////////////////////////////////////////////////////////////////////////////
    // contents seeded to the address so the bench can mirror them
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i);
        end
    end
    always @(posedge clk) begin
        if (file_we) begin
            mem[file_waddr] <= file_wdata;
        end
    end
    // no read forwarding: a write lands one edge after it is shown
    assign file_rdata = mem[file_addr];
endmodule

// [verification/bsx_alu_tb.sv]
// self-checking bench for the alu slice against an integer reference model
module bsx_alu_tb import bsx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, sys_rst, op_valid, dest_sel, carry_flag, digit_carry_flag, zero_flag, file_we;
    bsx_op_t    op_code;
    logic [7:0] literal_in, file_rdata, acc_out, file_wdata;
    logic [6:0] file_addr, file_waddr;
    int         fail_count = 0, comparisons = 0, acc = 0, c = 0, dc = 0, z = 0, we = 0;
    int         wa, wd, a, f, r, ka, fa, dn, v, o, m [128];
    bsx_op_t    ops [8] = '{BSX_OP_NONE, BSX_OP_LSUB, BSX_OP_FSUB, BSX_OP_LXOR,
                            BSX_OP_FXOR, BSX_OP_SWAP, bsx_op_t'(3'h4), bsx_op_t'(3'h5)};
    bsx_alu bsx_alu_i (.clk, .sys_rst, .op_valid, .op_code, .literal_in, .file_addr,
        .file_rdata, .dest_sel, .acc_out, .carry_flag, .digit_carry_flag, .zero_flag,
        .file_we, .file_waddr, .file_wdata);
    bsx_file_model bsx_file_model_i (.clk, .file_addr, .file_we, .file_waddr, .file_wdata,
        .file_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    // one compare point for every result
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check_all();
        check("acc", acc_out, acc);
        check("carry", carry_flag, c);
        check("digit_carry", digit_carry_flag, dc);
        check("zero", zero_flag, z);
        check("file_we", file_we, we);
        if (we) begin
            check("file_waddr", file_waddr, wa);
            check("file_wdata", file_wdata, wd);
        end
    endtask
    // reference step; undefined codes and idle cycles leave everything alone
    task automatic model(bsx_op_t op, int k, int fx, int d);
        f = m[fx];
        r = -1;
        we = 0;
        case (op)
            BSX_OP_LSUB, BSX_OP_FSUB: begin
                a = (op == BSX_OP_LSUB) ? k : f;
                r = (a - acc) & 255;
                c = a >= acc;
                dc = (a % 16) >= (acc % 16);
                z = r == 0;
            end
            BSX_OP_LXOR, BSX_OP_FXOR: begin
                r = acc ^ ((op == BSX_OP_LXOR) ? k : f);
                z = r == 0;
            end
            BSX_OP_SWAP: r = (f % 16) * 16 + f / 16;
            default: ;
        endcase
        if (r >= 0 && d == 1 && op != BSX_OP_LSUB && op != BSX_OP_LXOR) begin
            we = 1;
            wa = fx;
            wd = r;
            m[fx] = r;
        end else if (r >= 0) begin
            acc = r;
        end
    endtask
    // back-to-back random ops over every code, then a second reset
    initial begin
        sys_rst = 1;
        op_valid = 0;
        op_code = BSX_OP_NONE;
        literal_in = 8'h00;
        file_addr = 7'h00;
        dest_sel = 0;
        for (int i = 0; i < 128; i++) m[i] = i;
        void'($urandom(32'hB023));
        repeat (6) @(posedge clk);
        sys_rst <= 0;
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk);
            {ka, fa, dn, o, v} = {$urandom % 256, $urandom % 128, $urandom % 2, $urandom % 8,
                                  int'($urandom % 8 != 0)};
            // equal operands hit the zero result with no borrow
            if (n % 40 == 0) ka = acc;
            // partner has no forwarding, so skip reading the address just written
            if (we == 1 && fa == wa) fa = (fa + 1) % 128;
            op_valid <= v[0];
            op_code <= ops[o];
            literal_in <= 8'(ka);
            file_addr <= 7'(fa);
            dest_sel <= dn[0];
            @(negedge clk) check_all();
            model(v ? ops[o] : BSX_OP_NONE, ka, fa, dn);
        end
        // last random op lands, then reset cuts in with op_valid left at its last random value
        @(posedge clk) sys_rst <= 1;
        @(negedge clk) check_all();
        // first op rides the edge that releases reset
        @(posedge clk) begin
            sys_rst <= 0;
            op_valid <= 1;
            op_code <= BSX_OP_LSUB;
            literal_in <= 8'h05;
        end
        {acc, c, dc, z, we} = '0;
        @(negedge clk) check_all();
        model(BSX_OP_LSUB, 5, 0, 0);
        @(posedge clk) op_valid <= 0;
        @(negedge clk) check_all();
        wrap_up();
    end
    // watchdog well beyond the 3000-cycle sequence
    initial begin
        #50000;
        fail_count++;
        wrap_up();
    end
endmodule
